// file: rtl/dct_ctrl.sv
`timescale 1ns/1ps
// How it works
// RULE_01: ACTIVE to a different bank waits at least 10 ns.
// RULE_02: READ waits 2 clocks after last write data; a READ taken in the same cycle as wr_last_i is not held back.
// RULE_03: refresh issued on average every 15.6 us or 7.8 us.
// RULE_04: gap between refreshes never beyond 140.6 us or 70.3 us.
// RULE_05: every row refreshed within 64 ms, evenly spread.
// RULE_06: backlog of owed refreshes never above eight.
// RULE_07: after self refresh exit, 75 ns before non-READ commands.
// RULE_08: after self refresh exit, 200 clocks before READ.
// RULE_09: strobe preamble set-up minimum is zero ns.
// RULE_10: write strobe driven valid no later than WRITE command.
// RULE_11: memory has one strobe per byte lane.
// RULE_12: memory refreshes itself while in self refresh.
// RULE_13: after AUTO REFRESH, 70 ns before the next command.
// RULE_14: clock enable held high throughout refresh cycle.
// RULE_15: after frequency change, reset DLL, 200 clocks before read.
// RULE_16: nanosecond minimums rounded up to cycles, enforced by down-counters.
module dct_ctrl #(
  parameter bit          LARGE_DENSITY = 1'b1,
  parameter int unsigned REFI_CYC      = LARGE_DENSITY ? dct_pkg::REFI_LARGE_CYC
                                                       : dct_pkg::REFI_SMALL_CYC,
  parameter int unsigned REFC_CYC      = LARGE_DENSITY ? dct_pkg::REFC_LARGE_CYC
                                                       : dct_pkg::REFC_SMALL_CYC,
  parameter int unsigned LANES         = 9
) (
  input  wire logic               sys_clk_i,
  input  wire logic               rst_b_i,
  input  wire logic               req_valid_i,
  input  wire dct_pkg::dct_ureq_t req_i,
  input  wire logic               wr_last_i,
  output logic                    req_ready_o,
  output dct_pkg::dct_pins_t      pins_o,
  output logic [LANES-1:0]        dqs_o,
  output logic [LANES-1:0]        dqs_oe_o,
  output logic [3:0]              ref_owed_o
);
  localparam int unsigned CW = 16;

  typedef enum logic [1:0] {
    DCT_ST_RUN = 2'b00,
    DCT_ST_REF = 2'b01,
    DCT_ST_SR  = 2'b11
  } dct_st_t;

  dct_st_t           st_ff;
  logic [CW-1:0]     act_cnt_ff, rfc_cnt_ff, xsnr_cnt_ff, rd_cnt_ff, wtr_cnt_ff;
  logic [CW-1:0]     refi_cnt_ff, refc_cnt_ff;
  logic [3:0]        owed_ff;
  logic [1:0]        last_bank_ff;
  logic              bank_open_ff;
  dct_pkg::dct_pins_t pins_ff;
  logic [LANES-1:0]  dqs_ff, dqs_oe_ff;
  logic              ref_tick, issue_ref, take, cmd_ok, need_ref;

  function automatic logic [CW-1:0] dec(input logic [CW-1:0] c);
    return (c == '0) ? '0 : c - 16'h0001;
  endfunction

  function automatic logic [CW-1:0] cyc(input int unsigned n);
    return n[CW-1:0];
  endfunction

  // refresh must go out: owed at the cap or max gap nearly reached
  assign need_ref = (owed_ff >= 4'(dct_pkg::MAX_POSTED_REFRESH)) ||
                    (refc_cnt_ff <= cyc(REFI_CYC)) ;
  assign ref_tick = (refi_cnt_ff == '0);

  always_comb begin
    cmd_ok = 1'b0;
    if (st_ff == DCT_ST_RUN && req_valid_i && rfc_cnt_ff == '0) begin
      unique case (req_i.kind)
        // RULE_01 act spacing
        dct_pkg::DCT_REQ_ACT:   cmd_ok = act_cnt_ff == '0 && xsnr_cnt_ff == '0;
        // RULE_02 write to read
        dct_pkg::DCT_REQ_READ:  cmd_ok = rd_cnt_ff == '0 && wtr_cnt_ff == '0;
        dct_pkg::DCT_REQ_SR_OUT: cmd_ok = 1'b0;
        default:                cmd_ok = xsnr_cnt_ff == '0;
      endcase
    end else if (st_ff == DCT_ST_SR && req_valid_i) begin
      cmd_ok = req_i.kind == dct_pkg::DCT_REQ_SR_OUT;
    end
  end

  // RULE_06 refresh takes priority once due
  assign issue_ref = st_ff == DCT_ST_RUN && owed_ff != 4'h0 && rfc_cnt_ff == '0 &&
                     xsnr_cnt_ff == '0 && (need_ref || !req_valid_i);
  assign take      = cmd_ok && !issue_ref;

  // RULE_03 average spacing ticker
  // RULE_05 even spread over retention period
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      refi_cnt_ff <= '0;
    end else if (ref_tick) begin
      refi_cnt_ff <= cyc(REFI_CYC - 1);
    end else begin
      refi_cnt_ff <= refi_cnt_ff - 16'h0001;
    end
  end

  // RULE_06 owed refresh backlog; tick and issue together cancel
  // RULE_12 self refresh covers owed rows, backlog cleared on entry
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      owed_ff <= 4'h0;
    end else if (st_ff == DCT_ST_SR) begin
      owed_ff <= 4'h0;
    end else if (ref_tick && !issue_ref) begin
      owed_ff <= owed_ff + 4'h1;
    end else if (!ref_tick && issue_ref) begin
      owed_ff <= owed_ff - 4'h1;
    end
  end

  // RULE_04 max gap watchdog
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      refc_cnt_ff <= cyc(REFC_CYC);
    end else if (issue_ref || st_ff == DCT_ST_SR) begin
      refc_cnt_ff <= cyc(REFC_CYC);
    end else begin
      refc_cnt_ff <= dec(refc_cnt_ff);
    end
  end

  // RULE_16 minimums as down-counters
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      act_cnt_ff   <= '0;
      last_bank_ff <= 2'h0;
      bank_open_ff <= 1'b0;
    end else if (take && req_i.kind == dct_pkg::DCT_REQ_ACT) begin
      act_cnt_ff   <= cyc(dct_pkg::ACT_GAP_CYC);
      last_bank_ff <= req_i.bank;
      bank_open_ff <= 1'b1;
    end else begin
      act_cnt_ff   <= dec(act_cnt_ff);
    end
  end

  // RULE_13 refresh cycle time
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rfc_cnt_ff <= '0;
    end else if (issue_ref) begin
      rfc_cnt_ff <= cyc(dct_pkg::RFC_CYC);
    end else begin
      rfc_cnt_ff <= dec(rfc_cnt_ff);
    end
  end

  // RULE_07 exit to non-read
  // RULE_08 exit to read
  // RULE_15 dll reset to read
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      xsnr_cnt_ff <= '0;
      rd_cnt_ff   <= '0;
    end else if (take && req_i.kind == dct_pkg::DCT_REQ_SR_OUT) begin
      xsnr_cnt_ff <= cyc(dct_pkg::XSNR_CYC);
      rd_cnt_ff   <= cyc(dct_pkg::SELF_REFRESH_EXIT_TO_READ_CK);
    end else if (take && req_i.kind == dct_pkg::DCT_REQ_DLL_RST) begin
      xsnr_cnt_ff <= dec(xsnr_cnt_ff);
      rd_cnt_ff   <= cyc(dct_pkg::DLL_RESET_TO_READ_CK);
    end else begin
      xsnr_cnt_ff <= dec(xsnr_cnt_ff);
      rd_cnt_ff   <= dec(rd_cnt_ff);
    end
  end

  // RULE_02 counted from last write data
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wtr_cnt_ff <= '0;
    end else if (wr_last_i) begin
      wtr_cnt_ff <= cyc(dct_pkg::WRITE_TO_READ_GAP_CK);
    end else begin
      wtr_cnt_ff <= dec(wtr_cnt_ff);
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_ff <= DCT_ST_RUN;
    end else begin
      unique case (st_ff)
        DCT_ST_RUN: if (issue_ref) begin
          st_ff <= DCT_ST_REF;
        end else if (take && req_i.kind == dct_pkg::DCT_REQ_SR_IN) begin
          st_ff <= DCT_ST_SR;
        end
        DCT_ST_REF: if (rfc_cnt_ff == 16'h0001) begin
          st_ff <= DCT_ST_RUN;
        end
        DCT_ST_SR:  if (take) begin
          st_ff <= DCT_ST_RUN;
        end
        default:    st_ff <= DCT_ST_RUN;
      endcase
    end
  end

  // RULE_14 cke high through refresh
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pins_ff <= '{cke: 1'b0, cmd: dct_pkg::DCT_CMD_DESEL, bank: 2'h0, addr: 13'h0000};
    end else begin
      pins_ff.cke  <= !((st_ff == DCT_ST_RUN && take &&
                         req_i.kind == dct_pkg::DCT_REQ_SR_IN) ||
                        (st_ff == DCT_ST_SR && !take));
      pins_ff.bank <= req_i.bank;
      pins_ff.addr <= req_i.addr;
      if (issue_ref) begin
        pins_ff.cmd <= dct_pkg::DCT_CMD_REF;
      end else if (take) begin
        unique case (req_i.kind)
          dct_pkg::DCT_REQ_ACT:    pins_ff.cmd <= dct_pkg::DCT_CMD_ACT;
          dct_pkg::DCT_REQ_READ:   pins_ff.cmd <= dct_pkg::DCT_CMD_READ;
          dct_pkg::DCT_REQ_WRITE:  pins_ff.cmd <= dct_pkg::DCT_CMD_WRITE;
          dct_pkg::DCT_REQ_PRE:    pins_ff.cmd <= dct_pkg::DCT_CMD_PRE;
          dct_pkg::DCT_REQ_SR_IN:  pins_ff.cmd <= dct_pkg::DCT_CMD_REF;
          dct_pkg::DCT_REQ_DLL_RST: pins_ff.cmd <= dct_pkg::DCT_CMD_LMR;
          default:                 pins_ff.cmd <= dct_pkg::DCT_CMD_NOP;
        endcase
      end else begin
        pins_ff.cmd <= dct_pkg::DCT_CMD_NOP;
      end
    end
  end

  // RULE_09 preamble driven with the write, setup of zero met
  // RULE_10 strobe valid low by the write command
  // RULE_11 one strobe per byte lane
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dqs_ff    <= '0;
      dqs_oe_ff <= '0;
    end else if (take && req_i.kind == dct_pkg::DCT_REQ_WRITE) begin
      dqs_ff    <= '0;
      dqs_oe_ff <= '1;
    end else if (wr_last_i) begin
      dqs_oe_ff <= '0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      req_ready_o <= 1'b0;
    end else begin
      req_ready_o <= take;
    end
  end

  assign pins_o     = pins_ff;
  assign dqs_o      = dqs_ff;
  assign dqs_oe_o   = dqs_oe_ff;
  assign ref_owed_o = owed_ff;

  // RULE_06 backlog cap
  chk_owed_cap: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    owed_ff <= 4'h8) else $error("refresh backlog above eight");
  // RULE_13 no command within refresh cycle
  chk_rfc_quiet: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    issue_ref |=> (pins_ff.cmd == dct_pkg::DCT_CMD_REF) ##1
    (pins_ff.cmd == dct_pkg::DCT_CMD_NOP) [*3]) else $error("command inside refresh");
  // RULE_14 cke during refresh
  chk_cke_ref: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    issue_ref |=> pins_ff.cke [*4]) else $error("cke low during refresh");
  // RULE_01 act spacing
  chk_act_gap: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (take && req_i.kind == dct_pkg::DCT_REQ_ACT) |=> !(take &&
    req_i.kind == dct_pkg::DCT_REQ_ACT)) else $error("activates too close");
  // RULE_02 write to read
  chk_wtr_gap: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    wr_last_i |=> !(take && req_i.kind == dct_pkg::DCT_REQ_READ) [*2])
    else $error("read too soon after write");
  // RULE_08 read after exit
  chk_xsrd_gap: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (take && req_i.kind == dct_pkg::DCT_REQ_SR_OUT) |=>
    rd_cnt_ff == cyc(dct_pkg::SELF_REFRESH_EXIT_TO_READ_CK))
    else $error("exit to read counter not loaded");
  // RULE_07 non-read after exit
  chk_xsnr_gap: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (take && req_i.kind == dct_pkg::DCT_REQ_SR_OUT) |=> !take [*4])
    else $error("command too soon after self refresh exit");
  // RULE_04 watchdog never expires
  chk_refc_live: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    st_ff == DCT_ST_RUN |-> refc_cnt_ff != '0) else $error("max refresh gap exceeded");
endmodule : dct_ctrl

// file: rtl/dct_pkg.sv
package dct_pkg;
  // system clock period in picoseconds (50 MHz)
  localparam int unsigned CLK_PERIOD_PS = 20000;

  // timing figures in their own units (ps for ns-figures, ns for us-figures)
  localparam int unsigned ACT_TO_ACT_OTHER_BANK_GAP_PS = 10000;
  localparam int unsigned REFRESH_CYCLE_TIME_PS        = 70000;
  localparam int unsigned SELF_REFRESH_EXIT_TO_CMD_PS  = 75000;
  localparam int unsigned WRITE_STROBE_PREAMBLE_SETUP_PS = 0;
  localparam int unsigned WRITE_TO_READ_GAP_CK         = 2;
  localparam int unsigned SELF_REFRESH_EXIT_TO_READ_CK = 200;
  localparam int unsigned DLL_RESET_TO_READ_CK         = 200;
  localparam int unsigned AVG_REFRESH_SPACING_SMALL_NS = 15600;
  localparam int unsigned AVG_REFRESH_SPACING_LARGE_NS = 7800;
  localparam int unsigned MAX_REFRESH_GAP_SMALL_NS     = 140600;
  localparam int unsigned MAX_REFRESH_GAP_LARGE_NS     = 70300;
  localparam int unsigned RETENTION_PERIOD_MS          = 64;
  localparam int unsigned MAX_POSTED_REFRESH           = 8;

  // least times round up, longest times round down, never below one cycle
  function automatic int unsigned ceil_cyc(input int unsigned ps);
    int unsigned c;
    c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c == 0) ? 1 : c;
  endfunction

  function automatic int unsigned floor_cyc_ns(input int unsigned ns);
    int unsigned c;
    c = (ns * 1000) / CLK_PERIOD_PS;
    return (c == 0) ? 1 : c;
  endfunction

  localparam int unsigned ACT_GAP_CYC   = ceil_cyc(ACT_TO_ACT_OTHER_BANK_GAP_PS);
  localparam int unsigned RFC_CYC       = ceil_cyc(REFRESH_CYCLE_TIME_PS);
  localparam int unsigned XSNR_CYC      = ceil_cyc(SELF_REFRESH_EXIT_TO_CMD_PS);
  localparam int unsigned WPRES_CYC     = ceil_cyc(WRITE_STROBE_PREAMBLE_SETUP_PS);
  localparam int unsigned REFI_SMALL_CYC = floor_cyc_ns(AVG_REFRESH_SPACING_SMALL_NS);
  localparam int unsigned REFI_LARGE_CYC = floor_cyc_ns(AVG_REFRESH_SPACING_LARGE_NS);
  localparam int unsigned REFC_SMALL_CYC = floor_cyc_ns(MAX_REFRESH_GAP_SMALL_NS);
  localparam int unsigned REFC_LARGE_CYC = floor_cyc_ns(MAX_REFRESH_GAP_LARGE_NS);

  // command encoding on the pins: {cs_n, ras_n, cas_n, we_n}
  typedef enum logic [3:0] {
    DCT_CMD_DESEL = 4'hf,
    DCT_CMD_NOP   = 4'h7,
    DCT_CMD_ACT   = 4'h3,
    DCT_CMD_READ  = 4'h5,
    DCT_CMD_WRITE = 4'h4,
    DCT_CMD_PRE   = 4'h2,
    DCT_CMD_REF   = 4'h1,
    DCT_CMD_LMR   = 4'h0
  } dct_cmd_t;

  // user request kinds
  typedef enum logic [2:0] {
    DCT_REQ_ACT   = 3'h0,
    DCT_REQ_READ  = 3'h1,
    DCT_REQ_WRITE = 3'h2,
    DCT_REQ_PRE   = 3'h3,
    DCT_REQ_SR_IN = 3'h4,
    DCT_REQ_SR_OUT = 3'h5,
    DCT_REQ_DLL_RST = 3'h6,
    DCT_REQ_OTHER = 3'h7
  } dct_req_t;

  typedef struct packed {
    dct_req_t    kind;
    logic [1:0]  bank;
    logic [12:0] addr;
  } dct_ureq_t;

  typedef struct packed {
    logic        cke;
    dct_cmd_t    cmd;
    logic [1:0]  bank;
    logic [12:0] addr;
  } dct_pins_t;
endpackage : dct_pkg

// file: sim/dct_mem_model.sv
`timescale 1ns/1ps
module dct_mem_model #(
  parameter int unsigned REFC_CYC = 360
) (
  input  wire logic               sys_clk_i,
  input  wire logic               rst_b_i,
  input  wire dct_pkg::dct_pins_t pins_i,
  input  wire logic [8:0]         dqs_oe_i,
  input  wire logic               wr_last_i,
  output int                      viol_o,
  output int                      ref_cnt_o
);
  int                cyc_ff;
  int                act_ff;
  int                ref_ff;
  int                wend_ff;
  int                srx_ff;
  int                dll_ff;
  logic              sr_ff;
  dct_pkg::dct_cmd_t cmd;
  logic              quiet;

  assign cmd   = pins_i.cmd;
  assign quiet = (cmd == dct_pkg::DCT_CMD_NOP) || (cmd == dct_pkg::DCT_CMD_DESEL);

  always @(posedge sys_clk_i or negedge rst_b_i) begin : mon
    int v;
    v = 0;
    if (!rst_b_i) begin
      cyc_ff    <= 0;
      act_ff    <= -1000;
      ref_ff    <= -8;
      wend_ff   <= -1000;
      srx_ff    <= -1000;
      dll_ff    <= -1000;
      sr_ff     <= 1'b0;
      viol_o    <= 0;
      ref_cnt_o <= 0;
    end else begin
      cyc_ff <= cyc_ff + 1;
      if (wr_last_i) wend_ff <= cyc_ff;
      if (cmd == dct_pkg::DCT_CMD_ACT) begin
        act_ff <= cyc_ff;
        if (cyc_ff - act_ff < dct_pkg::ACT_GAP_CYC) v++;
      end
      if (!sr_ff && cyc_ff - ref_ff < dct_pkg::RFC_CYC && (!quiet || !pins_i.cke)) v++;
      if (cmd == dct_pkg::DCT_CMD_REF && pins_i.cke) begin
        ref_ff    <= cyc_ff;
        ref_cnt_o <= ref_cnt_o + 1;
      end
      if (!sr_ff && cyc_ff - ref_ff == REFC_CYC + 1) v++;
      if (cmd == dct_pkg::DCT_CMD_REF && !pins_i.cke) sr_ff <= 1'b1;
      if (sr_ff && pins_i.cke) begin
        sr_ff  <= 1'b0;
        srx_ff <= cyc_ff;
        ref_ff <= cyc_ff;
      end
      if (cmd == dct_pkg::DCT_CMD_READ && cyc_ff - wend_ff < dct_pkg::WRITE_TO_READ_GAP_CK) v++;
      if (!quiet && cmd != dct_pkg::DCT_CMD_READ && cyc_ff - srx_ff < dct_pkg::XSNR_CYC) v++;
      if (cmd == dct_pkg::DCT_CMD_READ && cyc_ff - srx_ff < 200) v++;
      if (cmd == dct_pkg::DCT_CMD_LMR) dll_ff <= cyc_ff;
      if (cmd == dct_pkg::DCT_CMD_READ && cyc_ff - dll_ff < 200) v++;
      if (cmd == dct_pkg::DCT_CMD_WRITE && dqs_oe_i !== 9'h1ff) v++;
      viol_o <= viol_o + v;
    end
  end
endmodule // dct_mem_model

// file: sim/tb.sv
`timescale 1ns/1ps
module tb;
  logic               sys_clk = 1'b0;
  logic               rst_b = 1'b0;
  logic               req_valid = 1'b0;
  logic               wr_last = 1'b0;
  dct_pkg::dct_ureq_t req = '0;
  logic               req_ready;
  dct_pkg::dct_pins_t pins;
  logic [8:0]         dqs;
  logic [8:0]         dqs_oe;
  logic [3:0]         ref_owed;
  int                 viol;
  int                 ref_cnt;
  int                 cyc = 0;
  int                 mismatches = 0;
  int                 n_checks = 0;

  always #10 sys_clk = ~sys_clk;

  dct_ctrl #(.REFI_CYC(40), .REFC_CYC(360)) dct_ctrl_inst (
    .sys_clk_i(sys_clk), .rst_b_i(rst_b), .req_valid_i(req_valid), .req_i(req),
    .wr_last_i(wr_last), .req_ready_o(req_ready), .pins_o(pins), .dqs_o(dqs),
    .dqs_oe_o(dqs_oe), .ref_owed_o(ref_owed));

  dct_mem_model #(.REFC_CYC(360)) dct_mem_model_inst (
    .sys_clk_i(sys_clk), .rst_b_i(rst_b), .pins_i(pins), .dqs_oe_i(dqs_oe),
    .wr_last_i(wr_last), .viol_o(viol), .ref_cnt_o(ref_cnt));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc >= 6000) begin
      mismatches++;
      stop_test();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  always @(negedge sys_clk) if (rst_b && ref_owed > 4'h8) chk("ref_owed", ref_owed, 32'h8);

  task automatic step();
    @(posedge sys_clk);
    #1;
  endtask

  // hold the request until the one-cycle ready pulse, then release
  task automatic issue(input dct_pkg::dct_req_t k, input logic [1:0] b, output int t,
                       output dct_pkg::dct_pins_t p, input bit keep = 1'b0);
    int n;
    @(negedge sys_clk);
    req_valid = 1'b1;
    req.kind = k;
    req.bank = b;
    n = 0;
    do begin
      step();
      n++;
    end while (req_ready !== 1'b1 && n < 800);
    t = cyc;
    p = pins;
    chk("req_taken", n < 800, 1);
    // keep set: valid stays up so the next request follows back to back
    if (!keep) begin
      @(negedge sys_clk);
      req_valid = 1'b0;
    end
  endtask

  task automatic t_reset();
    step();
    chk("cke_rst", pins.cke, 0);
    chk("cmd_rst", pins.cmd, dct_pkg::DCT_CMD_DESEL);
    chk("ready_rst", req_ready, 0);
    chk("owed_rst", ref_owed, 0);
    chk("oe_rst", dqs_oe, 0);
    repeat (3) @(negedge sys_clk);
    rst_b = 1'b1;
    step();
    chk("cmd_run", pins.cmd, dct_pkg::DCT_CMD_NOP);
    chk("cke_run", pins.cke, 1);
    $display("test reset done");
  endtask

  task automatic t_act();
    int t0, t1;
    dct_pkg::dct_pins_t p;
    issue(dct_pkg::DCT_REQ_ACT, 2'h0, t0, p, 1'b1);
    chk("act_cmd", p.cmd, dct_pkg::DCT_CMD_ACT);
    issue(dct_pkg::DCT_REQ_ACT, 2'h1, t1, p);
    chk("act_bank", p.bank, 2'h1);
    chk("act_gap", t1 - t0 >= dct_pkg::ACT_GAP_CYC, 1);
    $display("test act done");
  endtask

  task automatic t_wtr();
    int t0, w;
    dct_pkg::dct_pins_t p;
    issue(dct_pkg::DCT_REQ_WRITE, 2'h0, t0, p);
    chk("wr_cmd", p.cmd, dct_pkg::DCT_CMD_WRITE);
    chk("wr_strobe_oe", dqs_oe, 9'h1ff);
    chk("wr_strobe_lvl", dqs, 9'h000);
    wr_last = 1'b1;
    step();
    w = cyc;
    @(negedge sys_clk);
    wr_last = 1'b0;
    issue(dct_pkg::DCT_REQ_READ, 2'h0, t0, p);
    chk("rd_cmd", p.cmd, dct_pkg::DCT_CMD_READ);
    chk("wtr_gap", t0 - w >= dct_pkg::WRITE_TO_READ_GAP_CK, 1);
    $display("test write-read done");
  endtask

  task automatic t_refresh();
    int r0, n, tr, t;
    dct_pkg::dct_pins_t p;
    r0 = ref_cnt;
    repeat (400) step();
    n = ref_cnt - r0;
    chk("ref_rate", n >= 9 && n <= 11, 1);
    n = 0;
    do begin
      step();
      n++;
    end while (pins.cmd !== dct_pkg::DCT_CMD_REF && n < 100);
    tr = cyc;
    chk("ref_cke", pins.cke, 1);
    issue(dct_pkg::DCT_REQ_ACT, 2'h2, t, p);
    chk("rfc_gap", t - tr >= dct_pkg::RFC_CYC, 1);
    $display("test refresh done");
  endtask

  task automatic t_selfref();
    int t0, t1, r0;
    dct_pkg::dct_pins_t p;
    issue(dct_pkg::DCT_REQ_SR_IN, 2'h0, t0, p);
    chk("sr_cmd", p.cmd, dct_pkg::DCT_CMD_REF);
    chk("sr_cke", p.cke, 0);
    r0 = ref_cnt;
    repeat (400) step();
    chk("sr_no_ref", ref_cnt - r0, 0);
    issue(dct_pkg::DCT_REQ_SR_OUT, 2'h0, t0, p);
    issue(dct_pkg::DCT_REQ_PRE, 2'h0, t1, p);
    chk("pre_cmd", p.cmd, dct_pkg::DCT_CMD_PRE);
    chk("xsnr_gap", t1 - t0 >= dct_pkg::XSNR_CYC, 1);
    issue(dct_pkg::DCT_REQ_READ, 2'h0, t1, p);
    chk("xsrd_gap", t1 - t0 >= dct_pkg::SELF_REFRESH_EXIT_TO_READ_CK, 1);
    $display("test self refresh done");
  endtask

  task automatic t_dll();
    int t0, t1;
    dct_pkg::dct_pins_t p;
    issue(dct_pkg::DCT_REQ_DLL_RST, 2'h0, t0, p);
    chk("dll_cmd", p.cmd, dct_pkg::DCT_CMD_LMR);
    issue(dct_pkg::DCT_REQ_READ, 2'h0, t1, p);
    chk("dll_gap", t1 - t0 >= dct_pkg::DLL_RESET_TO_READ_CK, 1);
    $display("test dll done");
  endtask

  initial begin
    t_reset();
    t_act();
    t_wtr();
    t_refresh();
    t_selfref();
    t_dll();
    chk("model_viol", viol, 0);
    stop_test();
  end
endmodule // tb
